// ==== eeprom_rd_mem.sv ====
// Memory end: two-wire target with word counter and read path
//============================================================
// Operation
// - Read starts like write, direction bit one.
// - Current, random and sequential reads supported.
// - Counter holds last accessed location plus one.
// - Counter persists between transfers while powered.
// - Read increment wraps end of memory to zero.
// - Write increment wraps within current page.
// - After read address, shift byte MSB first.
// - Single read ends with no-ack then stop.
// - Random read first writes word address only.
// - Controller repeats start after word address ack.
// - Reissued read address returns newly loaded byte.
// - Sequential read follows current or random read.
// - Controller acks to request another byte.
// - Each controller ack advances counter, sends next.
// - Sequential read wraps past top, continues.
// - No-ack and stop end read, release line.
// - Ack only matching address, else standby.
// - Device ack sits in ninth clock pulse.
// - Large variant uses third select bit as page.
// - Word address is one byte after address.
`timescale 1ns/100ps
`default_nettype none
module eeprom_rd_mem #(
  parameter  int MEM_BYTES = eeprom_rd_pkg::MEM_BYTES_SMALL,
  // Counter width follows capacity, so it is not free to set
  localparam int ADDR_W    = (MEM_BYTES > eeprom_rd_pkg::MEM_BYTES_SMALL) ? 9 : 8
) (
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  eeprom_link_if.mem                 link,
  input  wire logic [2:0]            hardwired_select_pins,
  input  wire logic                  wr_en,
  input  wire logic [ADDR_W-1:0]     wr_addr,
  input  wire logic [7:0]            wr_data,
  output logic [ADDR_W-1:0]          word_counter,
  output logic                       read_active
);
  localparam int PAGE_W = (MEM_BYTES > 256) ? 4 : 3;
  localparam logic LARGE = (MEM_BYTES > 256);

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_DEV   = 6'b000010,
    ST_WADDR = 6'b000100,
    ST_WDATA = 6'b001000,
    ST_RDATA = 6'b010000,
    ST_MACK  = 6'b100000
  } state_e;

  typedef struct packed {
    logic [1:0]        scl_sync;
    logic [1:0]        sda_sync;
    logic              scl_d;
    logic              sda_d;
    state_e            state;
    logic [3:0]        bit_idx;
    logic [7:0]        shreg;
    logic [ADDR_W-1:0] counter;
    logic              sda_out;
    logic              sda_oe_n;
    logic              active;
  } mem_s;

  mem_s r;
  mem_s next_r;
  logic [7:0] mem [MEM_BYTES];

  function automatic logic [ADDR_W-1:0] read_inc(input logic [ADDR_W-1:0] a);
    return ADDR_W'((a + 1'b1) % MEM_BYTES);
  endfunction

  // Write wrap keeps page bits fixed
  function automatic logic [ADDR_W-1:0] write_inc(input logic [ADDR_W-1:0] a);
    logic [PAGE_W-1:0] lo;
    lo = a[PAGE_W-1:0] + 1'b1;
    return {a[ADDR_W-1:PAGE_W], lo};
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic addr_match;

  always_comb begin
    scl_rise   = r.scl_sync[1] & ~r.scl_d;
    scl_fall   = ~r.scl_sync[1] & r.scl_d;
    start_cond = r.scl_sync[1] & r.scl_d & r.sda_d & ~r.sda_sync[1];
    stop_cond  = r.scl_sync[1] & r.scl_d & ~r.sda_d & r.sda_sync[1];
    // Select match, third bit skipped in large variant
    addr_match = (r.shreg[7:4] == eeprom_rd_pkg::DEV_TYPE_CODE) &&
                 (r.shreg[3:2] == hardwired_select_pins[2:1]) &&
                 (LARGE || (r.shreg[1] == hardwired_select_pins[0]));
  end

  always_comb begin
    next_r = r;
    next_r.scl_sync = {r.scl_sync[0], link.scl};
    next_r.sda_sync = {r.sda_sync[0], link.sda};
    next_r.scl_d = r.scl_sync[1];
    next_r.sda_d = r.sda_sync[1];
    if (stop_cond) begin
      next_r.state    = ST_IDLE;
      next_r.sda_oe_n = 1'b1;
      next_r.sda_out  = 1'b1;
      next_r.active   = 1'b0;
    end else if (start_cond) begin
      next_r.state    = ST_DEV;
      next_r.bit_idx  = 4'h0;
      next_r.sda_oe_n = 1'b1;
      next_r.active   = 1'b0;
    end else if (scl_rise && r.state != ST_IDLE) begin
      if (r.bit_idx == eeprom_rd_pkg::ACK_SLOT_IDX) begin
        if (r.state == ST_MACK) begin
          if (!r.sda_sync[1]) begin
            next_r.state = ST_RDATA;
            next_r.shreg = mem[r.counter];
          end else begin
            next_r.state = ST_IDLE;
          end
        end
      end else if (r.state != ST_RDATA) begin
        next_r.shreg = {r.shreg[6:0], r.sda_sync[1]};
      end
      next_r.bit_idx = (r.bit_idx == eeprom_rd_pkg::ACK_SLOT_IDX) ? 4'h0 : r.bit_idx + 1'b1;
    end else if (scl_fall && r.state != ST_IDLE) begin
      next_r.sda_oe_n = 1'b1;
      next_r.sda_out  = 1'b1;
      if (r.bit_idx == eeprom_rd_pkg::BITS_PER_WORD[3:0] && r.state != ST_RDATA) begin
        case (r.state)
          ST_DEV: begin
            if (addr_match) begin
              next_r.sda_oe_n = 1'b0;
              next_r.sda_out  = 1'b0;
              if (LARGE && ADDR_W > 8) begin
                next_r.counter[ADDR_W-1] = r.shreg[1];
              end
              if (r.shreg[0] == eeprom_rd_pkg::DIR_READ) begin
                next_r.state = ST_RDATA;
                next_r.active = 1'b1;
              end else begin
                next_r.state = ST_WADDR;
              end
            end else begin
              next_r.state = ST_IDLE;
            end
          end
          ST_WADDR: begin
            next_r.sda_oe_n = 1'b0;
            next_r.sda_out  = 1'b0;
            next_r.counter[7:0] = r.shreg;
            next_r.state = ST_WDATA;
          end
          ST_WDATA: begin
            next_r.sda_oe_n = 1'b0;
            next_r.sda_out  = 1'b0;
            next_r.counter  = write_inc(r.counter);
          end
          default: next_r.state = ST_IDLE;
        endcase
      end else if (r.bit_idx == 4'h0 && r.state == ST_RDATA) begin
        next_r.shreg    = mem[r.counter];
        next_r.sda_oe_n = mem[r.counter][7];
        next_r.sda_out  = mem[r.counter][7];
        next_r.counter  = read_inc(r.counter);
      end else if (r.bit_idx == 4'h9 || (r.bit_idx == 4'h0 && r.state == ST_MACK)) begin
        next_r.sda_oe_n = 1'b1;
      end else if (r.state == ST_RDATA && r.bit_idx < eeprom_rd_pkg::BITS_PER_WORD[3:0]) begin
        next_r.sda_oe_n = r.shreg[7 - r.bit_idx[2:0]];
        next_r.sda_out  = r.shreg[7 - r.bit_idx[2:0]];
      end else if (r.state == ST_RDATA) begin
        next_r.state    = ST_MACK;
        next_r.sda_oe_n = 1'b1;
      end
    end
  end

  // counter only changes on bus activity or reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '{scl_sync: 2'h3, sda_sync: 2'h3, scl_d: 1'b1, sda_d: 1'b1, state: ST_IDLE,
             bit_idx: 4'h0, shreg: 8'h00, counter: '0,
             sda_out: 1'b1, sda_oe_n: 1'b1, active: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // Array preload port stands in for the excluded write path
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign link.sda_out_mem  = r.sda_out;
  assign link.sda_oe_n_mem = r.sda_oe_n;
  // counter is last access plus one
  assign word_counter = r.counter;
  // all three read kinds share ST_RDATA
  assign read_active = r.active;
endmodule
`default_nettype wire

// ==== eeprom_rd_pkg.sv ====
// Shared constants for the two-wire serial memory read engine
package eeprom_rd_pkg;
  localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
  localparam logic       DIR_READ      = 1'b1;
  localparam logic       DIR_WRITE     = 1'b0;
  localparam int         BITS_PER_WORD = 8;
  localparam logic [3:0] LAST_BIT_IDX  = 4'h7;
  localparam logic [3:0] ACK_SLOT_IDX  = 4'h8;
  localparam int         MEM_BYTES_SMALL = 256;
  localparam int         MEM_BYTES_LARGE = 512;
  localparam int         PAGE_BYTES_SMALL = 8;
  localparam int         PAGE_BYTES_LARGE = 16;
  // Link clock half period in core cycles for the controller end
  localparam int         SCL_HALF_CYCLES = 32;
  localparam int         SCL_DIV_W       = 6;
endpackage

// ==== eeprom_link_if.sv ====
// Two-wire link between controller end and memory end
`timescale 1ns/100ps
`default_nettype none
interface eeprom_link_if;
  logic scl;
  logic sda_out_ctl;
  logic sda_oe_n_ctl;
  logic sda_out_mem;
  logic sda_oe_n_mem;
  wire  sda;
  // Open drain: the line is low when any enabled driver pulls low
  assign sda = ~((~sda_oe_n_ctl & ~sda_out_ctl) | (~sda_oe_n_mem & ~sda_out_mem));
  modport ctl (output scl, output sda_out_ctl, output sda_oe_n_ctl, input sda);
  modport mem (input scl, output sda_out_mem, output sda_oe_n_mem, input sda);
endinterface
`default_nettype wire

// ==== eeprom_rd_ctl.sv ====
// Controller end: issues current, random and sequential reads
`timescale 1ns/100ps
`default_nettype none
module eeprom_rd_ctl (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  eeprom_link_if.ctl      link,
  input  wire logic       req,
  input  wire logic       random,
  input  wire logic [6:0] dev_addr,
  input  wire logic [7:0] word_addr,
  input  wire logic [7:0] byte_count,
  output logic            busy,
  output logic            byte_valid,
  output logic [7:0]      byte_data,
  output logic            nack_err
);
  typedef enum logic [7:0] {
    C_IDLE  = 8'b00000001, C_START = 8'b00000010, C_SEND = 8'b00000100,
    C_RECV  = 8'b00001000, C_ACK   = 8'b00010000, C_STOP = 8'b00100000,
    C_RSTRT = 8'b01000000, C_DONE  = 8'b10000000
  } cstate_e;

  typedef struct packed {
    cstate_e        state;
    logic [5:0]     div;
    logic [1:0]     phase;
    logic [3:0]     bit_idx;
    logic [7:0]     tx;
    logic [1:0]     step;
    logic [7:0]     left;
    logic [7:0]     rx;
    logic [1:0]     sda_sync;
    logic           rnd;
    logic           scl;
    logic           sda_oe_n;
    logic           busy;
    logic           bvalid;
    logic           nack;
  } ctl_s;

  ctl_s c;
  ctl_s next_c;
  logic tick;

  always_comb begin
    tick = (c.div == 6'(eeprom_rd_pkg::SCL_HALF_CYCLES / 2 - 1));
    next_c = c;
    next_c.sda_sync = {c.sda_sync[0], link.sda};
    next_c.bvalid = 1'b0;
    next_c.div = tick ? 6'h00 : c.div + 1'b1;
    if (c.state == C_IDLE) begin
      next_c.div = 6'h00;
      if (req) begin
        next_c.state = C_START;
        next_c.phase = 2'h0;
        next_c.rnd = random;
        next_c.left = byte_count;
        next_c.busy = 1'b1;
        next_c.nack = 1'b0;
        next_c.tx = {dev_addr, random ? eeprom_rd_pkg::DIR_WRITE : eeprom_rd_pkg::DIR_READ};
        next_c.step = random ? 2'h0 : 2'h2;
      end
    end else if (tick) begin
      next_c.phase = c.phase + 1'b1;
      case (c.state)
        C_START, C_RSTRT: begin
          case (c.phase)
            2'h0: begin next_c.sda_oe_n = 1'b1; next_c.scl = 1'b0; end
            2'h1: next_c.scl = 1'b1;
            2'h2: next_c.sda_oe_n = 1'b0;
            default: begin
              next_c.scl = 1'b0;
              next_c.state = C_SEND;
              next_c.bit_idx = 4'h0;
            end
          endcase
        end
        C_SEND, C_RECV: begin
          case (c.phase)
            2'h0: begin
              next_c.sda_oe_n = (c.bit_idx == eeprom_rd_pkg::ACK_SLOT_IDX) ?
                                (c.state == C_RECV ? (c.left <= 8'h1) : 1'b1) :
                                (c.state == C_SEND ? c.tx[7] : 1'b1);
            end
            2'h1: next_c.scl = 1'b1;
            2'h2: begin
              if (c.bit_idx == eeprom_rd_pkg::ACK_SLOT_IDX && c.state == C_SEND)
                next_c.nack = c.sda_sync[1];
              else if (c.state == C_RECV && c.bit_idx < eeprom_rd_pkg::ACK_SLOT_IDX)
                next_c.rx = {c.rx[6:0], c.sda_sync[1]};
            end
            default: begin
              next_c.scl = 1'b0;
              next_c.tx = {c.tx[6:0], 1'b0};
              next_c.bit_idx = c.bit_idx + 1'b1;
              if (c.bit_idx == eeprom_rd_pkg::ACK_SLOT_IDX) begin
                next_c.bit_idx = 4'h0;
                if (c.state == C_RECV) begin
                  next_c.bvalid = 1'b1;
                  next_c.left = c.left - 1'b1;
                  if (c.left <= 8'h1) next_c.state = C_STOP;
                end else if (c.nack) begin
                  next_c.state = C_STOP;
                end else if (c.step == 2'h0) begin
                  next_c.tx = word_addr;
                  next_c.step = 2'h1;
                end else if (c.step == 2'h1) begin
                  next_c.state = C_RSTRT;
                  next_c.tx = {dev_addr, eeprom_rd_pkg::DIR_READ};
                  next_c.step = 2'h2;
                end else begin
                  next_c.state = C_RECV;
                end
              end
            end
          endcase
        end
        C_STOP: begin
          case (c.phase)
            2'h0: next_c.sda_oe_n = 1'b0;
            2'h1: next_c.scl = 1'b1;
            2'h2: next_c.sda_oe_n = 1'b1;
            default: next_c.state = C_DONE;
          endcase
        end
        default: begin
          next_c.state = C_IDLE;
          next_c.busy = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      c <= '{state: C_IDLE, div: 6'h00, phase: 2'h0, bit_idx: 4'h0, tx: 8'h00, step: 2'h0,
             left: 8'h00, rx: 8'h00, sda_sync: 2'h3, rnd: 1'b0, scl: 1'b1,
             sda_oe_n: 1'b1, busy: 1'b0, bvalid: 1'b0, nack: 1'b0};
    end else begin
      c <= next_c;
    end
  end

  assign link.scl          = c.scl;
  assign link.sda_out_ctl  = 1'b0;
  assign link.sda_oe_n_ctl = c.sda_oe_n;
  assign busy       = c.busy;
  assign byte_valid = c.bvalid;
  assign byte_data  = c.rx;
  assign nack_err   = c.nack;
endmodule
`default_nettype wire

// ==== eeprom_rd_assertions.sv ====
// Link checker for the two-wire memory read engine
`timescale 1ns/100ps
`default_nettype none
module eeprom_rd_assertions #(
  parameter logic [2:0] SEL = 3'h5
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_out_ctl,
  input wire logic sda_oe_n_ctl,
  input wire logic sda_out_mem,
  input wire logic sda_oe_n_mem,
  input wire logic sda
);
  //==========================================================
  // Frame tracking
  logic       scl_q;
  logic       sda_q;
  logic       fr;
  logic       rd;
  logic       hit;
  logic       done;
  logic [3:0] bit_n;
  logic [1:0] byte_n;
  logic [8:0] sh;
  wire        rise  = scl & ~scl_q;
  wire        start = scl & scl_q & sda_q & ~sda;
  wire        stop  = scl & scl_q & ~sda_q & sda;
  wire        ack   = rise & fr & (bit_n == 4'h8);
  wire        match = sh[7:1] == {eeprom_rd_pkg::DEV_TYPE_CODE, SEL};
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      fr <= 1'b0;
      rd <= 1'b0;
      hit <= 1'b0;
      bit_n <= 4'h0;
      byte_n <= 2'h0;
      sh <= 9'h000;
      done <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        fr <= 1'b1;
        rd <= 1'b0;
        hit <= 1'b0;
        bit_n <= 4'h0;
        byte_n <= 2'h0;
        done <= 1'b0;
      end else if (stop) begin
        fr <= 1'b0;
      end else if (rise && fr) begin
        sh <= {sh[7:0], sda};
        bit_n <= (bit_n == 4'h8) ? 4'h0 : bit_n + 4'h1;
        if (ack && byte_n == 2'h0) begin
          rd <= sh[0];
          hit <= match;
        end
        if (ack && byte_n != 2'h3) begin
          byte_n <= byte_n + 2'h1;
        end
        // Controller no-ack ends the read; its stop then pulls the line low
        if (ack && rd && byte_n != 2'h0) begin
          done <= sda;
        end
      end
    end
  end
  //==========================================================
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_ADDR_ACK: assert property (ack && byte_n == 2'h0 && match |-> !sda && !sda_oe_n_mem)
    else $error("address not acknowledged");
  AST_ADDR_MISS: assert property (ack && byte_n == 2'h0 && !match |-> sda_oe_n_mem)
    else $error("foreign address acknowledged");
  AST_WORD_ACK: assert property (ack && byte_n == 2'h1 && !rd && hit |-> !sda)
    else $error("word address not acknowledged");
  AST_DATA_RELEASE: assert property (ack && rd && byte_n != 2'h0 |-> sda_oe_n_mem)
    else $error("line held in ninth slot after data");
  AST_QUIET_IN: assert property (rise && fr && bit_n != 4'h8 && (byte_n == 2'h0 || !rd)
    |-> sda_oe_n_mem)
    else $error("memory drove a controller bit");
  AST_CHANGE_LOW: assert property ($changed(sda_oe_n_mem) |-> !scl)
    else $error("memory drive changed with clock high");
  AST_PULL_LOW: assert property (!sda_oe_n_mem |-> !sda_out_mem)
    else $error("memory drove high");
  AST_STOP_RELEASE: assert property (stop |=> sda_oe_n_mem [*8])
    else $error("line held after stop");
  AST_CTL_LISTENS: assert property (rise && fr && rd && hit && byte_n != 2'h0 &&
    bit_n != 4'h8 && !done |-> sda_oe_n_ctl)
    else $error("controller drove during data");
  COV_SEQ_ACK: cover property (ack && rd && byte_n != 2'h0 && !sda);
  COV_MISS: cover property (ack && byte_n == 2'h0 && !match);
  COV_RESTART: cover property (start && fr);
endmodule
`default_nettype wire

// ==== serial_eeprom_read_engine_bench.sv ====
// Bench joining the controller end to the memory end
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_read_engine_bench;
  localparam logic [2:0] SEL = 3'h5;
  localparam logic [6:0] DEV = {eeprom_rd_pkg::DEV_TYPE_CODE, SEL};
  logic       core_clk   = 1'b0;
  logic       nrst       = 1'b0;
  logic       req        = 1'b0;
  logic       random     = 1'b0;
  logic [6:0] dev_addr   = DEV;
  logic [7:0] word_addr  = 8'h00;
  logic [7:0] byte_count = 8'h01;
  logic       wr_en      = 1'b0;
  logic [7:0] wr_addr    = 8'h00;
  logic [7:0] wr_data    = 8'h00;
  logic [7:0] cnt        = 8'h00;
  logic [7:0] word_counter;
  logic [7:0] byte_data;
  logic       busy;
  logic       byte_valid;
  logic       nack_err;
  logic       read_active;
  logic [24:0] rows [5];
  int         n_fail      = 0;
  int         check_count = 0;
  eeprom_link_if link();
  always #2.5 core_clk = ~core_clk;
  eeprom_rd_mem #(.MEM_BYTES(eeprom_rd_pkg::MEM_BYTES_SMALL)) i_eeprom_rd_mem (
    .core_clk(core_clk), .nrst(nrst), .link(link), .hardwired_select_pins(SEL),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .word_counter(word_counter),
    .read_active(read_active));
  eeprom_rd_ctl i_eeprom_rd_ctl (
    .core_clk(core_clk), .nrst(nrst), .link(link), .req(req), .random(random),
    .dev_addr(dev_addr), .word_addr(word_addr), .byte_count(byte_count), .busy(busy),
    .byte_valid(byte_valid), .byte_data(byte_data), .nack_err(nack_err));
  eeprom_rd_assertions #(.SEL(SEL)) i_eeprom_rd_assertions (
    .core_clk(core_clk), .nrst(nrst), .scl(link.scl), .sda_out_ctl(link.sda_out_ctl),
    .sda_oe_n_ctl(link.sda_oe_n_ctl), .sda_out_mem(link.sda_out_mem),
    .sda_oe_n_mem(link.sda_oe_n_mem), .sda(link.sda));
  //==========================================================
  // Checking and transfer tasks
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    check_count++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Runs one read; memory holds address xor 5A, so every byte is predictable
  task automatic rd(input logic rnd, input logic [7:0] wa, input logic [7:0] n,
                    input logic [6:0] da);
    int  got;
    int  k;
    logic hit;
    got = 0;
    k = 0;
    hit = (da === DEV);
    random = rnd;
    word_addr = wa;
    byte_count = n;
    dev_addr = da;
    req = 1'b1;
    @(negedge core_clk);
    req = 1'b0;
    if (rnd && hit) cnt = wa;
    while ((busy === 1'b1 || k < 4) && k < 40000) begin
      @(negedge core_clk);
      k++;
      if (byte_valid === 1'b1) begin
        chk("byte_data", {1'b0, cnt ^ 8'h5A}, {1'b0, byte_data});
        chk("read_active", 9'h001, {8'h00, read_active});
        cnt++;
        got++;
      end
    end
    if (k >= 40000) n_fail++;
    chk("read_active idle", 9'h000, {8'h00, read_active});
    chk("byte total", hit ? {1'b0, n} : 9'h000, got[8:0]);
    chk("nack_err", {8'h00, !hit}, {8'h00, nack_err});
    chk("word_counter", {1'b0, cnt}, {1'b0, word_counter});
  endtask
  //==========================================================
  // Main sequence: rows hold mode, word address, length and final counter
  initial begin
    rows = '{{1'b1, 8'h10, 8'h01, 8'h11}, {1'b0, 8'h00, 8'h01, 8'h12},
             {1'b0, 8'h00, 8'h03, 8'h15}, {1'b1, 8'hFD, 8'h05, 8'h02},
             {1'b1, 8'h80, 8'h02, 8'h82}};
    repeat (12) @(negedge core_clk);
    nrst = 1'b1;
    @(negedge core_clk);
    chk("busy", 9'h000, {8'h00, busy});
    chk("idle link", 9'h007, {6'h00, link.scl, link.sda_oe_n_ctl, link.sda_oe_n_mem});
    chk("reset counter", 9'h000, {1'b0, word_counter});
    for (int a = 0; a < 256; a++) begin
      wr_en = 1'b1;
      wr_addr = a[7:0];
      wr_data = a[7:0] ^ 8'h5A;
      @(negedge core_clk);
    end
    wr_en = 1'b0;
    @(negedge core_clk);
    foreach (rows[i]) begin
      rd(rows[i][24], rows[i][23:16], rows[i][15:8], DEV);
      chk("row end counter", {1'b0, rows[i][7:0]}, {1'b0, word_counter});
    end
    // Foreign select bits must leave the counter where it was
    rd(1'b1, 8'h40, 8'h01, {eeprom_rd_pkg::DEV_TYPE_CODE, 3'h2});
    rd(1'b0, 8'h00, 8'h02, DEV);
    // Reset mid-run returns the counter to its power-on value
    nrst = 1'b0;
    repeat (2) @(negedge core_clk);
    nrst = 1'b1;
    cnt = 8'h00;
    @(negedge core_clk);
    chk("counter after reset", 9'h000, {1'b0, word_counter});
    rd(1'b0, 8'h00, 8'h01, DEV);
    print_verdict();
  end
  initial begin
    #400000;
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire
